// file: include/ext_exec_pkg.sv
// types and constants of the execution core
// assumes one clock domain shared with the instruction stream and the buses
package ext_exec_pkg;

    // register field codes of the 3-bit selector
    localparam logic [2:0] G_B   = 3'h0;
    localparam logic [2:0] G_C   = 3'h1;
    localparam logic [2:0] G_D   = 3'h2;
    localparam logic [2:0] G_E   = 3'h3;
    localparam logic [2:0] G_H   = 3'h4;
    localparam logic [2:0] G_L   = 3'h5;
    localparam logic [2:0] G_A   = 3'h7;

    // pair field codes for the multiply
    localparam logic [1:0] PAIR_COUNT  = 2'h0;
    localparam logic [1:0] PAIR_SECOND = 2'h1;
    localparam logic [1:0] PAIR_MEMPTR = 2'h2;
    localparam logic [1:0] PAIR_STACK  = 2'h3;

    // special register codes for the special load
    localparam logic [2:0] SPC_VECTOR  = 3'h0;
    localparam logic [2:0] SPC_INDEX1  = 3'h1;
    localparam logic [2:0] SPC_INDEX2  = 3'h2;
    localparam logic [2:0] SPC_STACK   = 3'h3;

    // flag bit positions
    localparam int F_S  = 7;
    localparam int F_Z  = 6;
    localparam int F_H  = 4;
    localparam int F_PV = 2;
    localparam int F_N  = 1;
    localparam int F_C  = 0;

    // misc constants
    localparam int         REFRESH_BITS = 7;
    localparam logic [7:0] IO_HIGH_BYTE = 8'h00;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [15:0] RST_WORD    = 16'h0000;

    // decoded operations
    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_SLEEP,
        OP_MULT,
        OP_OUT_UP,
        OP_OUT_UP_RPT,
        OP_OUT_DN,
        OP_OUT_DN_RPT,
        OP_PORT_TEST,
        OP_TEST_REG,
        OP_TEST_IMM,
        OP_TEST_MEM,
        OP_PZ_READ,
        OP_PZ_WRITE,
        OP_EX_ACC_FLAGS,
        OP_EX_ALL,
        OP_LOAD_REG,
        OP_LOAD_SPECIAL
    } op_e;

    // gray-coded sequencer states
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_MEM_RD = 2'b01,
        ST_IO_WR  = 2'b11,
        ST_IO_RD  = 2'b10
    } seq_e;

    // one register set (main or shadow)
    typedef struct packed {
        logic [7:0]  acc;
        logic [7:0]  flags;
        logic [15:0] count_port_pair;
        logic [15:0] second_general_pair;
        logic [15:0] memory_pointer_pair;
    } reg_set_s;

    // decoded command from the instruction stream
    typedef struct packed {
        logic        valid;
        op_e         op;
        logic [2:0]  sel;
        logic [1:0]  pair;
        logic [15:0] data;
    } cmd_s;

    // memory and i/o bus request
    typedef struct packed {
        logic        mem_rd;
        logic        io_rd;
        logic        io_wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } bus_s;

    // programmer-visible registers
    typedef struct packed {
        reg_set_s    main_reg_set;
        logic [7:0]  vector_base;
        logic [7:0]  refresh_tally;
        logic [15:0] first_index;
        logic [15:0] second_index;
        logic [15:0] sp;
        logic [15:0] pc;
    } view_s;

    // whole state of the core
    typedef struct packed {
        reg_set_s    main_reg_set;
        reg_set_s    shadow_reg_set;
        logic [7:0]  vector_base;
        logic [7:0]  refresh_tally;
        logic [15:0] first_index;
        logic [15:0] second_index;
        logic [15:0] sp;
        logic [15:0] pc;
        seq_e        seq;
        op_e         op;
        logic [2:0]  sel;
        logic [7:0]  imm;
        bus_s        bus;
        logic        sleeping;
        logic        ready;
    } core_s;

endpackage : ext_exec_pkg

// file: core/ext_exec_core.sv
// execution core for the added instructions and the register file
// assumes decoded commands, bus acks and fetch pulses all arrive on REF_CLK
//
// Behaviour
// - multiply pair halves unsigned into same pair
// - block step: memory to port, count down
// - repeat variants loop until count is zero
// - high address byte is zero on i/o
// - port test ANDs port, flags only
// - register test keeps accumulator and register
// - immediate test keeps accumulator
// - memory test leaves memory and accumulator
// - page-zero read loads selected register
// - page-zero write sends selected register
// - sleep operation enters sleep state
// - main set: accumulator, flags, three pairs
// - shadow set swapped by exchange operations
// - vector, refresh, two index, stack, pc
// - vector base clears to zero on reset
// - refresh low seven bits count fetches
// - stack pointer and pc clear on reset
// - sign and zero flags from result
`timescale 1ns/1ps
`default_nettype none

module ext_exec_core
    import ext_exec_pkg::*;
(
    input  wire logic       REF_CLK,
    input  wire logic       NRST,
    input  wire cmd_s       CMD,
    input  wire logic       FETCH_M1,
    input  wire logic       WAKE,
    input  wire logic       BUS_ACK,
    input  wire logic [7:0] BUS_RDATA,
    output logic            CMD_READY,
    output bus_s            BUS,
    output logic            SLEEP_ACTIVE,
    output view_s           VIEW
);

    core_s st_reg;   // registered state
    core_s st_next;  // next state

    // read an 8-bit register of a set by its selector
    function automatic logic [7:0] get8(input reg_set_s s, input logic [2:0] g);
        logic [7:0] v;
        v = RST_BYTE;
        case (g)
            G_B:     v = s.count_port_pair[15:8];
            G_C:     v = s.count_port_pair[7:0];
            G_D:     v = s.second_general_pair[15:8];
            G_E:     v = s.second_general_pair[7:0];
            G_H:     v = s.memory_pointer_pair[15:8];
            G_L:     v = s.memory_pointer_pair[7:0];
            G_A:     v = s.acc;
            default: v = RST_BYTE;
        endcase
        return v;
    endfunction : get8

    // write an 8-bit register of a set, halves stay independent
    function automatic reg_set_s put8(input reg_set_s s, input logic [2:0] g,
                                      input logic [7:0] v);
        reg_set_s r;
        r = s;
        case (g)
            G_B:     r.count_port_pair[15:8]     = v;
            G_C:     r.count_port_pair[7:0]      = v;
            G_D:     r.second_general_pair[15:8] = v;
            G_E:     r.second_general_pair[7:0]  = v;
            G_H:     r.memory_pointer_pair[15:8] = v;
            G_L:     r.memory_pointer_pair[7:0]  = v;
            G_A:     r.acc                       = v;
            default: r = s;
        endcase
        return r;
    endfunction : put8

    // flags after a non-destructive AND
    function automatic logic [7:0] test_flags(input logic [7:0] f, input logic [7:0] res);
        logic [7:0] o;
        o       = f;
        o[F_S]  = res[7];
        o[F_Z]  = (res == RST_BYTE);
        o[F_H]  = 1'b1;
        o[F_PV] = ~^res;
        o[F_N]  = 1'b0;
        o[F_C]  = 1'b0;
        return o;
    endfunction : test_flags

    // unsigned 8x8 product of a pair's halves
    function automatic logic [15:0] mul_halves(input logic [15:0] p);
        return {8'h00, p[15:8]} * {8'h00, p[7:0]};
    endfunction : mul_halves

    // next-state logic
    always_comb begin
        logic        up;      // block step direction
        logic        rpt;     // block step repeats
        logic [7:0]  cnt;     // count byte after the step
        logic [7:0]  port;    // port byte after the step
        logic [15:0] ptr;     // pointer after the step
        up      = 1'b0;
        rpt     = 1'b0;
        cnt     = RST_BYTE;
        port    = RST_BYTE;
        ptr     = RST_WORD;
        st_next = st_reg;

        // refresh tally and pc advance on every opcode fetch
        if (FETCH_M1) begin
            st_next.refresh_tally[REFRESH_BITS-1:0] =
                st_reg.refresh_tally[REFRESH_BITS-1:0] + 7'h01;
            st_next.pc = st_reg.pc + 16'h0001;
        end

        case (st_reg.seq)
            // accept a new command or sit asleep
            ST_IDLE: begin
                if (st_reg.sleeping) begin
                    if (WAKE) begin
                        st_next.sleeping = 1'b0;
                    end
                end else if (CMD.valid) begin
                    st_next.op  = CMD.op;
                    st_next.sel = CMD.sel;
                    st_next.imm = CMD.data[7:0];
                    case (CMD.op)
                        // stop until woken
                        OP_SLEEP: begin
                            st_next.sleeping = 1'b1;
                        end
                        // product replaces the selected pair
                        OP_MULT: begin
                            case (CMD.pair)
                                PAIR_COUNT: st_next.main_reg_set.count_port_pair =
                                    mul_halves(st_reg.main_reg_set.count_port_pair);
                                PAIR_SECOND: st_next.main_reg_set.second_general_pair =
                                    mul_halves(st_reg.main_reg_set.second_general_pair);
                                PAIR_MEMPTR: st_next.main_reg_set.memory_pointer_pair =
                                    mul_halves(st_reg.main_reg_set.memory_pointer_pair);
                                default: st_next.sp = mul_halves(st_reg.sp);
                            endcase
                        end
                        // block output and the memory test start with the memory read
                        OP_OUT_UP, OP_OUT_UP_RPT, OP_OUT_DN, OP_OUT_DN_RPT,
                        OP_TEST_MEM: begin
                            st_next.bus.mem_rd = 1'b1;
                            st_next.bus.addr   = st_reg.main_reg_set.memory_pointer_pair;
                            st_next.seq        = ST_MEM_RD;
                        end
                        // port test reads the port in the count pair's low byte
                        OP_PORT_TEST: begin
                            st_next.bus.io_rd = 1'b1;
                            st_next.bus.addr  = {IO_HIGH_BYTE,
                                st_reg.main_reg_set.count_port_pair[7:0]};
                            st_next.seq       = ST_IO_RD;
                        end
                        // page-zero read from the immediate port
                        OP_PZ_READ: begin
                            st_next.bus.io_rd = 1'b1;
                            st_next.bus.addr  = {IO_HIGH_BYTE, CMD.data[7:0]};
                            st_next.seq       = ST_IO_RD;
                        end
                        // page-zero write of the selected register
                        OP_PZ_WRITE: begin
                            st_next.bus.io_wr = 1'b1;
                            st_next.bus.addr  = {IO_HIGH_BYTE, CMD.data[7:0]};
                            st_next.bus.wdata = get8(st_reg.main_reg_set, CMD.sel);
                            st_next.seq       = ST_IO_WR;
                        end
                        // register test, operands untouched
                        OP_TEST_REG: begin
                            st_next.main_reg_set.flags = test_flags(st_reg.main_reg_set.flags,
                                st_reg.main_reg_set.acc &
                                get8(st_reg.main_reg_set, CMD.sel));
                        end
                        // immediate test, accumulator untouched
                        OP_TEST_IMM: begin
                            st_next.main_reg_set.flags = test_flags(st_reg.main_reg_set.flags,
                                st_reg.main_reg_set.acc & CMD.data[7:0]);
                        end
                        // swap accumulator and flags with the shadow
                        OP_EX_ACC_FLAGS: begin
                            st_next.main_reg_set.acc     = st_reg.shadow_reg_set.acc;
                            st_next.main_reg_set.flags   = st_reg.shadow_reg_set.flags;
                            st_next.shadow_reg_set.acc   = st_reg.main_reg_set.acc;
                            st_next.shadow_reg_set.flags = st_reg.main_reg_set.flags;
                        end
                        // swap the three pairs with the shadow
                        OP_EX_ALL: begin
                            st_next.main_reg_set.count_port_pair =
                                st_reg.shadow_reg_set.count_port_pair;
                            st_next.main_reg_set.second_general_pair =
                                st_reg.shadow_reg_set.second_general_pair;
                            st_next.main_reg_set.memory_pointer_pair =
                                st_reg.shadow_reg_set.memory_pointer_pair;
                            st_next.shadow_reg_set.count_port_pair =
                                st_reg.main_reg_set.count_port_pair;
                            st_next.shadow_reg_set.second_general_pair =
                                st_reg.main_reg_set.second_general_pair;
                            st_next.shadow_reg_set.memory_pointer_pair =
                                st_reg.main_reg_set.memory_pointer_pair;
                        end
                        // plain load of an 8-bit register
                        OP_LOAD_REG: begin
                            st_next.main_reg_set = put8(st_reg.main_reg_set, CMD.sel,
                                                        CMD.data[7:0]);
                        end
                        // load of a special register
                        OP_LOAD_SPECIAL: begin
                            case (CMD.sel)
                                SPC_VECTOR: st_next.vector_base  = CMD.data[7:0];
                                SPC_INDEX1: st_next.first_index  = CMD.data;
                                SPC_INDEX2: st_next.second_index = CMD.data;
                                SPC_STACK:  st_next.sp           = CMD.data;
                                default:    st_next.sp           = st_reg.sp;
                            endcase
                        end
                        default: st_next.seq = ST_IDLE;
                    endcase
                end
            end

            // wait for the memory byte
            ST_MEM_RD: begin
                if (BUS_ACK) begin
                    st_next.bus.mem_rd = 1'b0;
                    if (st_reg.op == OP_TEST_MEM) begin
                        st_next.main_reg_set.flags = test_flags(st_reg.main_reg_set.flags,
                            st_reg.main_reg_set.acc & BUS_RDATA);
                        st_next.seq = ST_IDLE;
                    end else begin
                        st_next.bus.io_wr = 1'b1;
                        st_next.bus.addr  = {IO_HIGH_BYTE,
                            st_reg.main_reg_set.count_port_pair[7:0]};
                        st_next.bus.wdata = BUS_RDATA;
                        st_next.seq       = ST_IO_WR;
                    end
                end
            end

            // wait for the port write to finish
            ST_IO_WR: begin
                if (BUS_ACK) begin
                    st_next.bus.io_wr = 1'b0;
                    st_next.seq       = ST_IDLE;
                    if (st_reg.op != OP_PZ_WRITE) begin
                        up   = (st_reg.op == OP_OUT_UP) || (st_reg.op == OP_OUT_UP_RPT);
                        rpt  = (st_reg.op == OP_OUT_UP_RPT) || (st_reg.op == OP_OUT_DN_RPT);
                        cnt  = st_reg.main_reg_set.count_port_pair[15:8] - 8'h01;
                        port = up ? st_reg.main_reg_set.count_port_pair[7:0] + 8'h01
                                  : st_reg.main_reg_set.count_port_pair[7:0] - 8'h01;
                        ptr  = up ? st_reg.main_reg_set.memory_pointer_pair + 16'h0001
                                  : st_reg.main_reg_set.memory_pointer_pair - 16'h0001;
                        st_next.main_reg_set.count_port_pair     = {cnt, port};
                        st_next.main_reg_set.memory_pointer_pair = ptr;
                        st_next.main_reg_set.flags[F_Z] = (cnt == RST_BYTE);
                        // another step only for the repeating forms
                        if (rpt && (cnt != RST_BYTE)) begin
                            st_next.bus.mem_rd = 1'b1;
                            st_next.bus.addr   = ptr;
                            st_next.seq        = ST_MEM_RD;
                        end
                    end
                end
            end

            // wait for the port read
            ST_IO_RD: begin
                if (BUS_ACK) begin
                    st_next.bus.io_rd = 1'b0;
                    st_next.seq       = ST_IDLE;
                    if (st_reg.op == OP_PORT_TEST) begin
                        st_next.main_reg_set.flags = test_flags(st_reg.main_reg_set.flags,
                            BUS_RDATA & st_reg.imm);
                    end else begin
                        st_next.main_reg_set = put8(st_reg.main_reg_set, st_reg.sel,
                                                    BUS_RDATA);
                    end
                end
            end

            default: st_next.seq = ST_IDLE;
        endcase

        // ready only when idle and awake
        st_next.ready = (st_next.seq == ST_IDLE) && !st_next.sleeping;
    end

    // state register, cleared to zero on reset
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state flops
    assign CMD_READY    = st_reg.ready;
    assign BUS          = st_reg.bus;
    assign SLEEP_ACTIVE = st_reg.sleeping;
    assign VIEW         = {st_reg.main_reg_set, st_reg.vector_base, st_reg.refresh_tally,
                           st_reg.first_index, st_reg.second_index, st_reg.sp, st_reg.pc};

endmodule : ext_exec_core

`default_nettype wire

// file: testbench/ext_exec_core_asserts.sv
// concurrent checks on the execution core ports
// assumes it is bound to the core and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module ext_exec_core_asserts
    import ext_exec_pkg::*;
(
    input wire logic       REF_CLK,
    input wire logic       NRST,
    input wire cmd_s       CMD,
    input wire logic       FETCH_M1,
    input wire logic       WAKE,
    input wire logic       BUS_ACK,
    input wire logic [7:0] BUS_RDATA,
    input wire logic       CMD_READY,
    input wire bus_s       BUS,
    input wire logic       SLEEP_ACTIVE,
    input wire view_s      VIEW
);
    logic        tk;  // command taken at this edge
    logic [7:0]  ac;  // accumulator
    logic [7:0]  fg;  // flags
    logic [15:0] cp;  // count and port pair
    assign tk = CMD.valid && CMD_READY;
    assign ac = VIEW.main_reg_set.acc;
    assign fg = VIEW.main_reg_set.flags;
    assign cp = VIEW.main_reg_set.count_port_pair;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    a_io_high_zero: assert property ((BUS.io_rd || BUS.io_wr) |-> BUS.addr[15:8] == 8'h00)
        else $error("i/o high address not zero");
    a_imm_test_flags: assert property (tk && CMD.op == OP_TEST_IMM |=> ac == $past(ac)
        && fg[F_Z] == (($past(ac) & $past(CMD.data[7:0])) == 8'h00) && fg[F_H] && !fg[F_C])
        else $error("immediate test result wrong");
    a_reg_test_keep: assert property (tk && CMD.op == OP_TEST_REG
        |=> $stable(ac) && $stable(VIEW.main_reg_set[47:0]))
        else $error("register test changed data");
    a_mult_count: assert property (tk && CMD.op == OP_MULT && CMD.pair == PAIR_COUNT
        |=> cp == $past(cp[15:8]) * $past(cp[7:0]))
        else $error("pair product wrong");
    a_sleep_entry: assert property (tk && CMD.op == OP_SLEEP |=> SLEEP_ACTIVE && !CMD_READY)
        else $error("sleep not entered");
    a_wake_exit: assert property (SLEEP_ACTIVE && WAKE |=> !SLEEP_ACTIVE && CMD_READY)
        else $error("wake ignored");
    a_block_data: assert property ($rose(BUS.io_wr) && $past(BUS.mem_rd)
        |-> $past(BUS_ACK) && BUS.wdata == $past(BUS_RDATA))
        else $error("block data not memory byte");
    a_port_test_read: assert property (tk && CMD.op == OP_PORT_TEST
        |=> BUS.io_rd && !BUS.io_wr && BUS.addr[7:0] == $past(cp[7:0]))
        else $error("port test access wrong");
    a_pz_read_addr: assert property (tk && CMD.op == OP_PZ_READ
        |=> BUS.io_rd && BUS.addr == {8'h00, $past(CMD.data[7:0])})
        else $error("page zero read wrong");
    a_refresh_step: assert property (FETCH_M1 && !SLEEP_ACTIVE |=> !VIEW.refresh_tally[7]
        && VIEW.refresh_tally[6:0] == $past(VIEW.refresh_tally[6:0]) + 7'h01)
        else $error("refresh count step wrong");
endmodule : ext_exec_core_asserts
`default_nettype wire

// file: testbench/test_extended_instruction_execution.sv
// self-checking bench for the execution core
// assumes the core package; the bench answers the bus itself
`timescale 1ns/1ps
`default_nettype none
module test_extended_instruction_execution;
    import ext_exec_pkg::*;
    logic        REF_CLK = 1'b0;   // system clock
    logic        NRST = 1'b0;      // reset, active low
    cmd_s        CMD = '0;         // command to the core
    logic        FETCH_M1 = 1'b0;  // fetch pulse
    logic        WAKE = 1'b0;      // wake level
    logic        BUS_ACK = 1'b0;   // bus completion
    logic [7:0]  BUS_RDATA = 8'h00; // bus read data
    logic        CMD_READY;        // core idle
    bus_s        BUS;              // bus request
    logic        SLEEP_ACTIVE;     // asleep
    view_s       VIEW;             // register view
    int          n_fail = 0;       // mismatches
    int          checks_done = 0;  // comparisons
    logic [31:0] seed = 32'hC987;  // random state
    logic [1:0]  lat = 2'h0;       // bus latency count
    logic        go;               // request awaiting ack
    logic [7:0]  r [8];            // expected registers
    logic [23:0] wq [$];           // port writes seen
    logic [7:0]  v;                // scratch byte
    logic [2:0]  g;                // register code
    logic [15:0] spv;              // stack value loaded
    int          n, p, d;          // counts and step
    ext_exec_core ext_exec_core_inst (.*);
    always #2 REF_CLK = ~REF_CLK;
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd
    // byte the bus model returns for an address
    function automatic logic [7:0] mem(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : mem
    function automatic logic [7:0] vr(input logic [2:0] k);
        logic [63:0] m;
        m = VIEW.main_reg_set;
        return (k == G_A) ? m[63:56] : m[47 - 8 * k -: 8];
    endfunction : vr
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // test flags: sign, zero, half set, parity, n and c clear
    task automatic fl(input logic [7:0] t);
        chk("flags", {8'h00, t[7], t == 8'h00, 2'b01, 1'b0, ~^t, 2'b00},
            {8'h00, VIEW.main_reg_set.flags & 8'hD7});
    endtask : fl
    task automatic chk_regs();
        for (int k = 0; k < 8; k++) begin
            if (k != 6) chk("register", {8'h00, r[k]}, {8'h00, vr(3'(k))});
        end
    endtask : chk_regs
    // offer a command, then wait until the core is idle again
    task automatic cmd(input op_e op, input logic [2:0] s, input logic [15:0] w = 16'h0000,
                       input logic [1:0] q = 2'h0);
        int k;
        k = 0;
        CMD <= {1'b1, op, s, q, w};
        @(posedge REF_CLK);
        CMD <= '0;
        @(posedge REF_CLK);
        while (CMD_READY !== 1'b1 && k < 100) begin
            @(posedge REF_CLK);
            k++;
        end
        @(posedge REF_CLK);
        if (k >= 100) chk("ready", 16'h0001, {15'h0, CMD_READY});
    endtask : cmd
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    // bus model: random latency, logs port writes
    always @(posedge REF_CLK) begin
        go = (BUS.mem_rd || BUS.io_rd || BUS.io_wr) && !BUS_ACK;
        if (BUS_ACK && BUS.io_wr) wq.push_back({BUS.addr, BUS.wdata});
        BUS_ACK <= go && lat == 2'h0;
        BUS_RDATA <= go ? mem(BUS.addr) : ~BUS_RDATA;
        if (go) lat <= (lat == 2'h0) ? seed[1:0] : lat - 2'h1;
    end
    initial begin
        repeat (20000) @(posedge REF_CLK);
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge REF_CLK);
        NRST <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        chk("vector", 16'h0000, {8'h00, VIEW.vector_base});
        chk("refresh", 16'h0000, {8'h00, VIEW.refresh_tally});
        chk("stack", 16'h0000, VIEW.sp);
        chk("pc", 16'h0000, VIEW.pc);
        // 130 fetches wrap the seven refresh bits once
        FETCH_M1 <= 1'b1;
        repeat (130) @(posedge REF_CLK);
        FETCH_M1 <= 1'b0;
        @(posedge REF_CLK);
        chk("refresh", 16'h0002, {8'h00, VIEW.refresh_tally});
        chk("pc", 16'h0082, VIEW.pc);
        for (int i = 0; i < 20; i++) begin
            foreach (r[k]) begin
                r[k] = (i < 2) ? {8{i[0]}} : rnd();
                if (k != 6) cmd(OP_LOAD_REG, 3'(k), {8'h00, r[k]});
            end
            spv = {r[1], r[0]};
            cmd(OP_LOAD_SPECIAL, SPC_STACK, spv);
            v = rnd();
            g = (v[2:0] == 3'h6) ? G_A : v[2:0];
            cmd(OP_TEST_REG, g);
            fl(r[g] & r[7]);
            cmd(OP_TEST_IMM, 3'h0, {8'h00, v});
            fl(v & r[7]);
            cmd(OP_TEST_MEM, 3'h0);
            fl(mem({r[4], r[5]}) & r[7]);
            n = wq.size();
            cmd(OP_PORT_TEST, 3'h0, {8'h00, v});
            fl(mem({8'h00, r[1]}) & v);
            chk("port writes", 16'(n), 16'(wq.size()));
            cmd(OP_PZ_WRITE, g, {8'h00, v});
            chk("write port", {8'h00, v}, wq[$][23:8]);
            chk("write data", {8'h00, r[g]}, {8'h00, wq[$][7:0]});
            cmd(OP_PZ_READ, g, {8'h00, ~v});
            r[g] = mem({8'h00, ~v});
            p = i % 4;
            cmd(OP_MULT, 3'h0, 16'h0000, 2'(p));
            if (p == 3) chk("stack product", spv[15:8] * spv[7:0], VIEW.sp);
            else {r[2 * p], r[2 * p + 1]} = r[2 * p] * r[2 * p + 1];
            chk_regs();
        end
        // block output, all four forms
        for (int j = 0; j < 4; j++) begin
            r[0] = (j == 0) ? 8'h01 : 8'h03;
            r[1] = rnd();
            r[4] = rnd();
            for (int k = 0; k < 6; k++) begin
                if (k < 2 || k > 3) cmd(OP_LOAD_REG, 3'(k), {8'h00, r[k]});
            end
            wq.delete();
            cmd(op_e'(int'(OP_OUT_UP) + j), 3'h0);
            d = j[1] ? -1 : 1;
            n = j[0] ? r[0] : 1;
            chk("block writes", 16'(n), 16'(wq.size()));
            for (int k = 0; k < n; k++) begin
                chk("block port", {8'h00, 8'(r[1] + d * k)}, wq[k][23:8]);
                chk("block data", {8'h00, mem(16'({r[4], r[5]} + d * k))},
                    {8'h00, wq[k][7:0]});
            end
            {r[4], r[5]} = 16'({r[4], r[5]} + d * n);
            r[0] = r[0] - 8'(n);
            r[1] = 8'(r[1] + d * n);
            chk_regs();
        end
        // main and shadow sets swap and swap back
        for (int j = 0; j < 2; j++) begin
            v = rnd();
            for (int k = 0; k < 2; k++) cmd(OP_LOAD_REG, k ? G_B : G_A, {8'h00, v});
            cmd(j ? OP_EX_ALL : OP_EX_ACC_FLAGS, 3'h0);
            for (int k = 0; k < 2; k++) cmd(OP_LOAD_REG, k ? G_B : G_A, {8'h00, ~v});
            cmd(j ? OP_EX_ALL : OP_EX_ACC_FLAGS, 3'h0);
            // the pair swap leaves the accumulator with its last load
            chk("swapped acc", {8'h00, j ? ~v : v}, {8'h00, vr(G_A)});
            chk("swapped pair", {8'h00, j ? v : ~v}, {8'h00, vr(G_B)});
        end
        CMD <= {1'b1, OP_SLEEP, 3'h0, 2'h0, 16'h0000};
        @(posedge REF_CLK);
        CMD <= '0;
        repeat (3) @(posedge REF_CLK);
        chk("asleep", 16'h0001, {15'h0, SLEEP_ACTIVE & ~CMD_READY});
        WAKE <= 1'b1;
        @(posedge REF_CLK);
        WAKE <= 1'b0;
        @(posedge REF_CLK);
        chk("awake", 16'h0001, {15'h0, ~SLEEP_ACTIVE & CMD_READY});
        wrap_up();
    end
endmodule : test_extended_instruction_execution
bind ext_exec_core ext_exec_core_asserts ext_exec_core_asserts_inst (.*);
`default_nettype wire
